// File: verilog/srg_pkg.sv
// Shared constants and types of the supervisor, reset and write guard block.
// Assumes a single 25 MHz system clock and a 32-bit APB register bus.
package srg_pkg;
	// System clock and the one millisecond time base
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned TICK_MS = 1;
	localparam int unsigned MS_TICK_CYCLES = CLK_HZ / MS_PER_S * TICK_MS;

	// Reset hold time per delay setting, in milliseconds
	localparam logic [15:0] HOLD_SEL0_MS = 16'h0032;
	localparam logic [15:0] HOLD_SEL1_MS = 16'h0064;
	localparam logic [15:0] HOLD_SEL2_MS = 16'h00c8;
	localparam logic [15:0] HOLD_SEL3_MS = 16'h012c;

	// Register byte offsets
	localparam int unsigned ADDR_W = 12;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_EVENT = 12'h008;
	localparam logic [11:0] ADDR_MASK = 12'h00c;

	// Control register fields
	localparam int unsigned CTRL_DELAY_LO = 0;
	localparam int unsigned CTRL_DELAY_HI = 1;
	localparam int unsigned CTRL_WEL = 2;
	localparam int unsigned CTRL_LOCK_LO = 3;
	localparam int unsigned CTRL_LOCK_HI = 4;
	localparam logic [1:0] DELAY_SEL_RESET = 2'h0;
	localparam logic [1:0] LOCK_RESET = 2'h0;

	// Live status register fields
	localparam int unsigned STAT_RESET = 0;
	localparam int unsigned STAT_MON_B = 1;
	localparam int unsigned STAT_MON_C = 2;
	localparam int unsigned STAT_WP = 3;
	localparam int unsigned STAT_SUPPLY_LOW = 4;
	localparam int unsigned STAT_MANUAL = 5;

	// Sticky event bits, shared by event and mask registers
	localparam int unsigned EV_MON_B = 0;
	localparam int unsigned EV_MON_C = 1;
	localparam int unsigned EV_RESET = 2;
	localparam int unsigned EV_REFUSED = 3;
	localparam int unsigned EV_W = 4;

	// Synchroniser lanes and their reset values
	localparam int unsigned SYN_SUPPLY = 0;
	localparam int unsigned SYN_MANUAL = 1;
	localparam int unsigned SYN_MON_B = 2;
	localparam int unsigned SYN_MON_C = 3;
	localparam int unsigned SYN_W = 4;
	localparam logic [3:0] SYN_RESET = 4'h1;

	// Reset output sequencing
	typedef enum logic [1:0] {
		SRG_ASSERT,
		SRG_HOLD,
		SRG_RUN
	} srg_phase_t;
endpackage : srg_pkg

// File: verilog/srg_sync.sv
// Two-stage level synchroniser, one lane per input bit.
// Assumes levels that change slowly against the system clock.
`timescale 1ns/1ns
module srg_sync #(
	parameter int unsigned WIDTH = 4,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} srg_sync_t;

	srg_sync_t s;
	srg_sync_t next_s;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("srg_sync needs at least one lane");
		end
	endgenerate

	always_comb begin
		next_s = s;
		for (int i = 0; i < WIDTH; i++) begin
			next_s.stage1[i] = async_in[i];
			next_s.stage2[i] = s.stage1[i];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= {RESET_VAL, RESET_VAL};
		end else begin
			s <= next_s;
		end
	end

	assign sync_out = s.stage2;
endmodule : srg_sync

// File: verilog/srg_supervisor.sv
// Supervisor: reset output sequencing, monitor flags, write guard, APB registers.
// Assumes comparator results as digital levels and an APB master on CLK.
//
// Contract
// - Reset output stays high while the supply-low comparator is active.
// - Reset asserted at power-up, held the selected time after supply stabilises.
// - Two delay select bits in the control register choose the hold time.
// - Manual reset input high starts a reset cycle, asserting reset output.
// - After manual reset falls, reset output stays high the selected hold time.
// - Write-protect high refuses every nonvolatile write.
// - Write-protect high with lock bits nonzero refuses every write, volatile too.
// - Monitor C flag follows its comparator, no added delay; the code lags it three clocks (two sync stages, one register).
// - Monitor B flag follows its comparator, no power-up hold delay.
// - Write-protect counts only when driven high; otherwise protection is off.
// - Hold time selectable from 50 to 300 milliseconds by select bits.
// - Monitor results latch into sticky software-readable status bits.
// - Array or potentiometer writes need the write enable latch set first.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ns
module srg_supervisor #(
	parameter int unsigned MS_TICK_CYCLES = srg_pkg::MS_TICK_CYCLES
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Comparator levels
	input wire logic SUPPLY_LOW_IN,
	input wire logic MANUAL_RESET_IN,
	input wire logic MONITOR_B_LEVEL_IN,
	input wire logic MONITOR_C_LEVEL_IN,
	// Supervisor outputs
	output logic RESET_OUT,
	output logic MONITOR_B_FLAG_OUT,
	output logic MONITOR_C_FLAG_OUT,
	output logic IRQ,
	// Write guard
	input wire logic WP_IN,
	input wire logic WR_REQ,
	input wire logic WR_NONVOL,
	input wire logic WR_ARRAY,
	output logic WR_GRANT,
	output logic WR_REFUSE
);
	localparam int unsigned TICK_W = $clog2(MS_TICK_CYCLES + 1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_TICK_CYCLES - 1);
	localparam logic [15:0] MS_ONE = 16'h0001;

	typedef struct packed {
		srg_pkg::srg_phase_t phase;
		logic [TICK_W-1:0] tick_cnt;
		logic [15:0] ms_cnt;
		logic [1:0] delay_sel;
		logic write_enable_latch;
		logic [1:0] lock;
		logic [srg_pkg::EV_W-1:0] ev_status;
		logic [srg_pkg::EV_W-1:0] ev_mask;
		logic reset_out;
		logic mon_b;
		logic mon_c;
		logic irq;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic wr_grant;
		logic wr_refuse;
	} srg_state_t;

	srg_state_t s;
	srg_state_t next_s;
	logic [srg_pkg::SYN_W-1:0] syn_in;
	logic [srg_pkg::SYN_W-1:0] syn;

	generate
		if (MS_TICK_CYCLES < 1) begin : g_bad_tick
			$error("MS_TICK_CYCLES must be at least one");
		end
		// Zero hold would wrap the counter
		if (srg_pkg::HOLD_SEL0_MS == '0 || srg_pkg::HOLD_SEL1_MS == '0 ||
				srg_pkg::HOLD_SEL2_MS == '0 || srg_pkg::HOLD_SEL3_MS == '0) begin : g_bad_hold
			$error("hold times must be at least one millisecond");
		end
	endgenerate

	// hold time range
	// Selected hold time in milliseconds
	function automatic logic [15:0] hold_ms(input logic [1:0] sel);
		logic [15:0] ms;
		ms = srg_pkg::HOLD_SEL0_MS;
		case (sel)
			2'h0: ms = srg_pkg::HOLD_SEL0_MS;
			2'h1: ms = srg_pkg::HOLD_SEL1_MS;
			2'h2: ms = srg_pkg::HOLD_SEL2_MS;
			default: ms = srg_pkg::HOLD_SEL3_MS;
		endcase
		return ms;
	endfunction : hold_ms

	always_comb begin
		syn_in = '0;
		syn_in[srg_pkg::SYN_SUPPLY] = SUPPLY_LOW_IN;
		syn_in[srg_pkg::SYN_MANUAL] = MANUAL_RESET_IN;
		syn_in[srg_pkg::SYN_MON_B] = MONITOR_B_LEVEL_IN;
		syn_in[srg_pkg::SYN_MON_C] = MONITOR_C_LEVEL_IN;
	end

	srg_sync #(
		.WIDTH(srg_pkg::SYN_W),
		.RESET_VAL(srg_pkg::SYN_RESET)
	) u_sync (
		.clk(CLK),
		.reset_n(RESET_N),
		.async_in(syn_in),
		.sync_out(syn)
	);

	always_comb begin
		logic cause;
		logic access;
		logic done;
		logic mapped;
		logic wp_on;
		logic refuse;
		logic [31:0] rd_data;
		logic [srg_pkg::EV_W-1:0] ev_set;
		logic [srg_pkg::EV_W-1:0] ev_clr;
		cause = 1'b0;
		access = 1'b0;
		done = 1'b0;
		mapped = 1'b0;
		wp_on = 1'b0;
		refuse = 1'b0;
		rd_data = '0;
		ev_set = '0;
		ev_clr = '0;
		next_s = s;

		cause = syn[srg_pkg::SYN_SUPPLY];
		cause = cause | syn[srg_pkg::SYN_MANUAL];

		case (s.phase)
			srg_pkg::SRG_ASSERT: begin
				next_s.reset_out = 1'b1;
				if (!cause) begin
					next_s.ms_cnt = hold_ms(s.delay_sel);
					next_s.tick_cnt = '0;
					next_s.phase = srg_pkg::SRG_HOLD;
				end
			end
			srg_pkg::SRG_HOLD: begin
				next_s.reset_out = 1'b1;
				if (cause) begin
					next_s.phase = srg_pkg::SRG_ASSERT;
				end else if (s.tick_cnt == TICK_LAST) begin
					next_s.tick_cnt = '0;
					if (s.ms_cnt == MS_ONE) begin
						next_s.phase = srg_pkg::SRG_RUN;
						next_s.reset_out = 1'b0;
					end else begin
						next_s.ms_cnt = s.ms_cnt - MS_ONE;
					end
				end else begin
					next_s.tick_cnt = s.tick_cnt + 1'b1;
				end
			end
			srg_pkg::SRG_RUN: begin
				next_s.reset_out = 1'b0;
				if (cause) begin
					next_s.phase = srg_pkg::SRG_ASSERT;
					next_s.reset_out = 1'b1;
					ev_set[srg_pkg::EV_RESET] = 1'b1;
				end
			end
			default: begin
				next_s.phase = srg_pkg::SRG_ASSERT;
				next_s.reset_out = 1'b1;
			end
		endcase

		next_s.mon_b = syn[srg_pkg::SYN_MON_B];
		next_s.mon_c = syn[srg_pkg::SYN_MON_C];
		ev_set[srg_pkg::EV_MON_B] = syn[srg_pkg::SYN_MON_B];
		ev_set[srg_pkg::EV_MON_C] = syn[srg_pkg::SYN_MON_C];

		wp_on = (WP_IN == 1'b1);
		refuse = wp_on & WR_NONVOL;
		refuse = refuse | (wp_on & (s.lock != srg_pkg::LOCK_RESET));
		refuse = refuse | (WR_ARRAY & !s.write_enable_latch);
		next_s.wr_grant = WR_REQ & !refuse;
		next_s.wr_refuse = WR_REQ & refuse;
		ev_set[srg_pkg::EV_REFUSED] = WR_REQ & refuse;

		// APB decode and read mux
		access = PSEL & PENABLE;
		done = access & s.pready;
		next_s.pready = access & !s.pready;
		if (PADDR == srg_pkg::ADDR_CTRL) begin
			mapped = 1'b1;
			rd_data[srg_pkg::CTRL_DELAY_LO] = s.delay_sel[0];
			rd_data[srg_pkg::CTRL_DELAY_HI] = s.delay_sel[1];
			rd_data[srg_pkg::CTRL_WEL] = s.write_enable_latch;
			rd_data[srg_pkg::CTRL_LOCK_LO] = s.lock[0];
			rd_data[srg_pkg::CTRL_LOCK_HI] = s.lock[1];
		end else if (PADDR == srg_pkg::ADDR_STATUS) begin
			mapped = 1'b1;
			rd_data[srg_pkg::STAT_RESET] = s.reset_out;
			rd_data[srg_pkg::STAT_MON_B] = s.mon_b;
			rd_data[srg_pkg::STAT_MON_C] = s.mon_c;
			rd_data[srg_pkg::STAT_WP] = wp_on;
			rd_data[srg_pkg::STAT_SUPPLY_LOW] = syn[srg_pkg::SYN_SUPPLY];
			rd_data[srg_pkg::STAT_MANUAL] = syn[srg_pkg::SYN_MANUAL];
		end else if (PADDR == srg_pkg::ADDR_EVENT) begin
			mapped = 1'b1;
			rd_data[srg_pkg::EV_W-1:0] = s.ev_status;
		end else if (PADDR == srg_pkg::ADDR_MASK) begin
			mapped = 1'b1;
			rd_data[srg_pkg::EV_W-1:0] = s.ev_mask;
		end

		if (access & !s.pready) begin
			next_s.prdata = PWRITE ? 32'h0 : rd_data;
			next_s.pslverr = !mapped;
		end else if (!access) begin
			next_s.prdata = '0;
			next_s.pslverr = 1'b0;
		end

		if (done & PWRITE & mapped) begin
			if (PADDR == srg_pkg::ADDR_CTRL) begin
				next_s.delay_sel = {PWDATA[srg_pkg::CTRL_DELAY_HI], PWDATA[srg_pkg::CTRL_DELAY_LO]};
				next_s.write_enable_latch = PWDATA[srg_pkg::CTRL_WEL];
				next_s.lock = {PWDATA[srg_pkg::CTRL_LOCK_HI], PWDATA[srg_pkg::CTRL_LOCK_LO]};
			end else if (PADDR == srg_pkg::ADDR_EVENT) begin
				ev_clr = PWDATA[srg_pkg::EV_W-1:0];
			end else if (PADDR == srg_pkg::ADDR_MASK) begin
				next_s.ev_mask = PWDATA[srg_pkg::EV_W-1:0];
			end
		end

		next_s.ev_status = (s.ev_status & ~ev_clr) | ev_set;
		next_s.irq = |(next_s.ev_status & next_s.ev_mask);
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			s.phase <= srg_pkg::SRG_ASSERT;
			s.tick_cnt <= '0;
			s.ms_cnt <= '0;
			s.delay_sel <= srg_pkg::DELAY_SEL_RESET;
			s.write_enable_latch <= 1'b0;
			s.lock <= srg_pkg::LOCK_RESET;
			s.ev_status <= '0;
			s.ev_mask <= '0;
			s.reset_out <= 1'b1;
			s.mon_b <= 1'b0;
			s.mon_c <= 1'b0;
			s.irq <= 1'b0;
			s.prdata <= '0;
			s.pready <= 1'b0;
			s.pslverr <= 1'b0;
			s.wr_grant <= 1'b0;
			s.wr_refuse <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from state flops
	assign PRDATA = s.prdata;
	assign PREADY = s.pready;
	assign PSLVERR = s.pslverr;
	assign RESET_OUT = s.reset_out;
	assign MONITOR_B_FLAG_OUT = s.mon_b;
	assign MONITOR_C_FLAG_OUT = s.mon_c;
	assign IRQ = s.irq;
	assign WR_GRANT = s.wr_grant;
	assign WR_REFUSE = s.wr_refuse;
endmodule : srg_supervisor

// File: verification/srg_supervisor_asserts.sv
// Checker on the supervisor top ports.
// Assumes a bind onto srg_supervisor.
`timescale 1ns/1ns
module srg_chk #(
	parameter int unsigned MS_TICK_CYCLES = srg_pkg::MS_TICK_CYCLES
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// APB
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PREADY,
	// Supervisor
	input wire logic SUPPLY_LOW_IN,
	input wire logic MANUAL_RESET_IN,
	input wire logic MONITOR_B_LEVEL_IN,
	input wire logic MONITOR_C_LEVEL_IN,
	input wire logic RESET_OUT,
	input wire logic MONITOR_B_FLAG_OUT,
	input wire logic MONITOR_C_FLAG_OUT,
	// Write guard
	input wire logic WP_IN,
	input wire logic WR_REQ,
	input wire logic WR_NONVOL,
	input wire logic WR_ARRAY,
	input wire logic WR_GRANT,
	input wire logic WR_REFUSE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	logic [31:0] quiet;
	// Cycles since last reset cause
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N)
			quiet <= 32'h0;
		else if (SUPPLY_LOW_IN || MANUAL_RESET_IN)
			quiet <= 32'h0;
		else if (quiet != 32'hffffffff)
			quiet <= quiet + 32'h1;
	end
	sequence s_access;
		(PSEL && !PENABLE) ##1 (PSEL && PENABLE);
	endsequence
	a_apb_wait: assert property (s_access |=> PREADY)
		else $error("apb answer late");
	a_flag_b: assert property (MONITOR_B_FLAG_OUT == $past(MONITOR_B_LEVEL_IN, 3))
		else $error("flag b wrong");
	a_flag_c: assert property (MONITOR_C_FLAG_OUT == $past(MONITOR_C_LEVEL_IN, 3))
		else $error("flag c wrong");
	a_supply_rst: assert property ($past(SUPPLY_LOW_IN, 3) |-> RESET_OUT)
		else $error("supply low no reset");
	a_manual_rst: assert property ($past(MANUAL_RESET_IN, 3) |-> RESET_OUT)
		else $error("manual no reset");
	a_hold_min: assert property ($fell(RESET_OUT) |-> quiet >= 50 * MS_TICK_CYCLES)
		else $error("hold too short");
	a_hold_max: assert property (quiet > 300 * MS_TICK_CYCLES + 8 |-> !RESET_OUT)
		else $error("hold too long");
	a_one_answer: assert property (WR_REQ |=> WR_GRANT ^ WR_REFUSE)
		else $error("write answer wrong");
	a_wp_nonvol: assert property (WR_REQ && WP_IN && WR_NONVOL |=> WR_REFUSE)
		else $error("protected write granted");
	a_wp_open: assert property (WR_REQ && !WP_IN && !WR_ARRAY |=> WR_GRANT)
		else $error("open write refused");
endmodule : srg_chk

// File: verification/srg_supervisor_tb.sv
// Self-checking bench of the supervisor block.
// Assumes a short tick so hold times stay small.
`timescale 1ns/1ns
module srg_supervisor_tb;
	localparam int unsigned M = 4;
	logic CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic SUPPLY_LOW_IN, MANUAL_RESET_IN, MONITOR_B_LEVEL_IN, MONITOR_C_LEVEL_IN;
	logic RESET_OUT, MONITOR_B_FLAG_OUT, MONITOR_C_FLAG_OUT, IRQ;
	logic WP_IN, WR_REQ, WR_NONVOL, WR_ARRAY, WR_GRANT, WR_REFUSE;
	logic [15:0] hms [4] = '{srg_pkg::HOLD_SEL0_MS, srg_pkg::HOLD_SEL1_MS, srg_pkg::HOLD_SEL2_MS,
		srg_pkg::HOLD_SEL3_MS};
	int failures = 0;
	int compares = 0;
	srg_supervisor #(.MS_TICK_CYCLES(M)) i_dut (.CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
		.PWDATA, .PRDATA, .PREADY, .PSLVERR, .SUPPLY_LOW_IN, .MANUAL_RESET_IN, .MONITOR_B_LEVEL_IN,
		.MONITOR_C_LEVEL_IN, .RESET_OUT, .MONITOR_B_FLAG_OUT, .MONITOR_C_FLAG_OUT, .IRQ, .WP_IN,
		.WR_REQ, .WR_NONVOL, .WR_ARRAY, .WR_GRANT, .WR_REFUSE);
	task end_sim;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge CLK);
	endtask : tick
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge CLK);
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'h1;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'h1 && n < 20);
		// Answer taken at the edge that samples ready
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		if (PREADY !== 1'h1) begin
			failures++;
			end_sim;
		end
	endtask : apb
	task wait_low(output int n);
		n = 0;
		do begin
			@(negedge CLK);
			n++;
		end while (RESET_OUT !== 1'h0 && n < 2000);
		if (n >= 2000) begin
			failures++;
			end_sim;
		end
	endtask : wait_low
	task hold(input logic [1:0] sel, input logic sup);
		int n;
		apb(1'h1, srg_pkg::ADDR_CTRL, {30'h0, sel});
		@(posedge CLK);
		if (sup)
			SUPPLY_LOW_IN <= 1'h1;
		else
			MANUAL_RESET_IN <= 1'h1;
		tick(6);
		SUPPLY_LOW_IN <= 1'h0;
		MANUAL_RESET_IN <= 1'h0;
		chk(RESET_OUT, 1);
		wait_low(n);
		chk(n >= hms[sel] * M && n <= hms[sel] * M + 6, 1);
	endtask : hold
	task restart;
		@(posedge CLK);
		MANUAL_RESET_IN <= 1'h1;
		tick(4);
		MANUAL_RESET_IN <= 1'h0;
		tick(100);
		hold(2'h0, 1'h1);
	endtask : restart
	task flags(input logic b, input logic c);
		@(posedge CLK);
		MONITOR_B_LEVEL_IN <= b;
		MONITOR_C_LEVEL_IN <= c;
		tick(3);
		@(negedge CLK);
		chk(MONITOR_B_FLAG_OUT, b);
		chk(MONITOR_C_FLAG_OUT, c);
	endtask : flags
	task mon;
		flags(1'h1, 1'h0);
		flags(1'h0, 1'h1);
		flags(1'h0, 1'h0);
		apb(1'h0, srg_pkg::ADDR_EVENT, 32'h0);
		chk(rd & 32'h3, 32'h3);
		apb(1'h1, srg_pkg::ADDR_MASK, 32'h1);
		tick(2);
		chk(IRQ, 1);
		apb(1'h1, srg_pkg::ADDR_EVENT, 32'h1);
		apb(1'h0, srg_pkg::ADDR_EVENT, 32'h0);
		chk(rd & 32'h3, 32'h2);
		chk(IRQ, 0);
		flags(1'h1, 1'h0);
		apb(1'h1, srg_pkg::ADDR_EVENT, 32'h1);
		apb(1'h0, srg_pkg::ADDR_EVENT, 32'h0);
		chk(rd & 32'h1, 32'h1);
		chk(IRQ, 1);
		flags(1'h0, 1'h0);
	endtask : mon
	task guard;
		logic [2:0] r;
		logic exp;
		for (int k = 0; k < 8; k++) begin
			apb(1'h1, srg_pkg::ADDR_CTRL, {27'h0, k[2:0], 2'h0});
			for (int i = 0; i < 8; i++) begin
				r = i[2:0];
				exp = !((r[0] & r[1]) | (r[0] & (k[2:1] != 0)) | (r[2] & !k[0]));
				@(posedge CLK);
				WP_IN <= r[0];
				WR_NONVOL <= r[1];
				WR_ARRAY <= r[2];
				WR_REQ <= 1'h1;
				@(posedge CLK);
				WR_REQ <= 1'h0;
				@(negedge CLK);
				chk(WR_GRANT, exp);
				chk(WR_REFUSE, !exp);
			end
		end
		WP_IN <= 1'h0;
	endtask : guard
	initial begin
		CLK = 1'h0;
		forever #20 CLK = ~CLK;
	end
	initial begin
		int n;
		{RESET_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA, SUPPLY_LOW_IN, MANUAL_RESET_IN} <= '0;
		{MONITOR_B_LEVEL_IN, MONITOR_C_LEVEL_IN, WP_IN, WR_REQ, WR_NONVOL, WR_ARRAY} <= '0;
		tick(16);
		RESET_N <= 1'h1;
		wait_low(n);
		chk(n >= 50 * M && n <= 50 * M + 6, 1);
		apb(1'h0, srg_pkg::ADDR_CTRL, 32'h0);
		chk(rd, 0);
		chk(err, 0);
		apb(1'h0, 12'h010, 32'h0);
		chk(err, 1);
		for (int s = 0; s < 4; s++)
			hold(s[1:0], s[0]);
		restart;
		mon;
		guard;
		end_sim;
	end
endmodule : srg_supervisor_tb
bind srg_supervisor srg_chk #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) i_chk (.CLK, .RESET_N, .PSEL, .PENABLE,
	.PREADY, .SUPPLY_LOW_IN, .MANUAL_RESET_IN, .MONITOR_B_LEVEL_IN, .MONITOR_C_LEVEL_IN, .RESET_OUT,
	.MONITOR_B_FLAG_OUT, .MONITOR_C_FLAG_OUT, .WP_IN, .WR_REQ, .WR_NONVOL, .WR_ARRAY, .WR_GRANT, .WR_REFUSE);
